//--- pkg/scp_pkg.sv
// constants for the secondary synthesiser register bank
`default_nettype none

package scp_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFF_RESERVED_SLOT     = 16'h0412;
	localparam logic [15:0] OFF_PLL_LOOP_SETUP    = 16'h0414;
	localparam logic [15:0] OFF_PLL_ANALOG_TRIM   = 16'h0416;
	localparam logic [15:0] OFF_PLL_POWER_CONTROL = 16'h0418;
	localparam logic [15:0] OFF_SYNTH_STATUS      = 16'h04FE;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_PLL_LOOP_SETUP    = 16'h0000;
	localparam logic [15:0] RST_PLL_ANALOG_TRIM   = 16'h0000;
	localparam logic [15:0] RST_PLL_POWER_CONTROL = 16'h0000;
	localparam logic [4:0]  RST_STATUS_STICKY     = 5'h00;
	localparam logic [15:0] RST_RDATA             = 16'h0000;

	// ------------------------------------------------------------
	// field positions of pll_loop_setup
	// ------------------------------------------------------------
	localparam int unsigned FLT_LSB   = 12;
	localparam int unsigned BAND_LSB  = 8;
	localparam int unsigned RSV_LSB   = 6;
	localparam int unsigned RATIO_LSB = 4;
	localparam int unsigned FB_LSB    = 0;
	// writable bits: all but 7-6
	localparam logic [15:0] LOOP_SETUP_WMASK = 16'hFF3F;
	localparam logic [15:0] POWER_CTRL_WMASK = 16'h0001;
	localparam int unsigned POWER_ON_BIT     = 0;

	// ------------------------------------------------------------
	// legal codes
	// ------------------------------------------------------------
	localparam logic [3:0] FLT_CODE_HIGH_REF = 4'h8;
	localparam logic [3:0] FLT_CODE_LOW_REF  = 4'hA;
	localparam logic [3:0] BAND_CODE_MIN     = 4'h1;
	localparam logic [3:0] BAND_CODE_MAX     = 4'h8;
	localparam logic [1:0] RATIO_CODE_X2     = 2'h1;
	localparam logic [1:0] RATIO_CODE_X4     = 2'h2;
	localparam logic [1:0] RATIO_CODE_X8     = 2'h3;
	localparam logic [3:0] RATIO_VALUE_X2    = 4'h2;
	localparam logic [3:0] RATIO_VALUE_X4    = 4'h4;
	localparam logic [3:0] RATIO_VALUE_X8    = 4'h8;
	localparam logic [3:0] RATIO_VALUE_NONE  = 4'h0;

	// ------------------------------------------------------------
	// status register bits
	// ------------------------------------------------------------
	localparam int unsigned ST_POWER_ON    = 0;
	localparam int unsigned ST_FLT_BAD     = 1;
	localparam int unsigned ST_BAND_BAD    = 2;
	localparam int unsigned ST_RATIO_BAD   = 3;
	localparam int unsigned ST_CFG_LIVE_WR = 4;
	localparam int unsigned ST_RSVD_WR     = 5;

endpackage : scp_pkg

`default_nettype wire

//--- pkg/scp_cfg_if.sv
// configuration fields passed from register bank to decoder
`timescale 1ns/100ps
`default_nettype none

interface scp_cfg_if;
	logic [3:0] filter_resistance_code;
	logic [3:0] vco_band_code;
	logic [1:0] vco_ratio_factor;
	logic [3:0] feedback_factor;
	logic       flt_bad;
	logic       band_bad;
	logic       ratio_bad;
	logic [3:0] ratio_value;
	logic [4:0] fb_multiplier;

	modport regs (
		output filter_resistance_code,
		output vco_band_code,
		output vco_ratio_factor,
		output feedback_factor,
		input  flt_bad,
		input  band_bad,
		input  ratio_bad,
		input  ratio_value,
		input  fb_multiplier
	);

	modport decode (
		input  filter_resistance_code,
		input  vco_band_code,
		input  vco_ratio_factor,
		input  feedback_factor,
		output flt_bad,
		output band_bad,
		output ratio_bad,
		output ratio_value,
		output fb_multiplier
	);
endinterface : scp_cfg_if

`default_nettype wire

//--- core/scp_cfg_decode.sv
// decoder of the loop setup fields into factors and legality flags
`timescale 1ns/100ps
`default_nettype none

module scp_cfg_decode (
	scp_cfg_if.decode cfg
);

	// ------------------------------------------------------------
	// factor decode
	// ------------------------------------------------------------
	always_comb begin
		unique case (cfg.vco_ratio_factor)
			scp_pkg::RATIO_CODE_X2: cfg.ratio_value = scp_pkg::RATIO_VALUE_X2;
			scp_pkg::RATIO_CODE_X4: cfg.ratio_value = scp_pkg::RATIO_VALUE_X4;
			scp_pkg::RATIO_CODE_X8: cfg.ratio_value = scp_pkg::RATIO_VALUE_X8;
			default:                cfg.ratio_value = scp_pkg::RATIO_VALUE_NONE;
		endcase
	end

	// output = reference times (field + 1)
	assign cfg.fb_multiplier = {1'b0, cfg.feedback_factor} + 5'h01;

	// ------------------------------------------------------------
	// reserved code detection
	// ------------------------------------------------------------
	assign cfg.flt_bad =
		(cfg.filter_resistance_code != scp_pkg::FLT_CODE_HIGH_REF) &&
		(cfg.filter_resistance_code != scp_pkg::FLT_CODE_LOW_REF);
	assign cfg.band_bad =
		(cfg.vco_band_code < scp_pkg::BAND_CODE_MIN) ||
		(cfg.vco_band_code > scp_pkg::BAND_CODE_MAX);
	assign cfg.ratio_bad =
		(cfg.ratio_value == scp_pkg::RATIO_VALUE_NONE);

endmodule : scp_cfg_decode

`default_nettype wire

//--- core/scp_pll_regs.sv
// register bank configuring and enabling the secondary synthesiser
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module scp_pll_regs (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	// register port
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// synthesiser controls
	output logic      [3:0]  o_filter_resistance_code,
	output logic      [3:0]  o_vco_band_code,
	output logic      [1:0]  o_vco_ratio_factor,
	output logic      [3:0]  o_feedback_factor,
	output logic      [15:0] o_analog_trim,
	output logic             o_synth_power_on,
	// decoded view
	output logic      [3:0]  o_vco_ratio_value,
	output logic      [4:0]  o_feedback_multiplier,
	output logic             o_cfg_reserved_code
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// masked merge keeps non-writable bits at their held value
	function automatic logic [15:0] scp_merge(
		input logic [15:0] held,
		input logic [15:0] wdata,
		input logic [15:0] wmask
	);
		scp_merge = (held & ~wmask) | (wdata & wmask);
	endfunction : scp_merge

	// exact match on the full byte offset, so no aliases
	function automatic logic scp_hit(
		input logic [15:0] addr,
		input logic [15:0] offset
	);
		scp_hit = (addr == offset);
	endfunction : scp_hit

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0] loop_setup_reg;
	logic [15:0] loop_setup_next;
	logic [15:0] analog_trim_reg;
	logic [15:0] analog_trim_next;
	logic [15:0] power_ctrl_reg;
	logic [15:0] power_ctrl_next;
	logic        live_wr_reg;
	logic        live_wr_next;
	logic        rsvd_wr_reg;
	logic        rsvd_wr_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	logic        wr_loop;
	logic        wr_trim;
	logic        wr_power;
	logic        wr_status;
	logic        wr_rsvd;
	logic [15:0] status_word;

	scp_cfg_if cfg ();

	scp_cfg_decode u_decode (
		.cfg (cfg.decode)
	);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// unmapped offsets fall through: writes dropped, reads zero
	assign wr_loop   = i_wr && scp_hit(i_addr, scp_pkg::OFF_PLL_LOOP_SETUP);
	assign wr_trim   = i_wr && scp_hit(i_addr, scp_pkg::OFF_PLL_ANALOG_TRIM);
	assign wr_power  = i_wr && scp_hit(i_addr, scp_pkg::OFF_PLL_POWER_CONTROL);
	assign wr_status = i_wr && scp_hit(i_addr, scp_pkg::OFF_SYNTH_STATUS);
	// the slot holds nothing; a write there is only recorded
	assign wr_rsvd   = i_wr && scp_hit(i_addr, scp_pkg::OFF_RESERVED_SLOT);

	// ------------------------------------------------------------
	// field fan-out to the decoder
	// ------------------------------------------------------------
	assign cfg.filter_resistance_code =
		loop_setup_reg[scp_pkg::FLT_LSB +: 4];
	assign cfg.vco_band_code =
		loop_setup_reg[scp_pkg::BAND_LSB +: 4];
	assign cfg.vco_ratio_factor =
		loop_setup_reg[scp_pkg::RATIO_LSB +: 2];
	assign cfg.feedback_factor =
		loop_setup_reg[scp_pkg::FB_LSB +: 4];

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	// flags 1-3 follow the fields live; bits 4-5 are sticky
	always_comb begin
		status_word                          = 16'h0000;
		status_word[scp_pkg::ST_POWER_ON]    =
			power_ctrl_reg[scp_pkg::POWER_ON_BIT];
		status_word[scp_pkg::ST_FLT_BAD]     = cfg.flt_bad;
		status_word[scp_pkg::ST_BAND_BAD]    = cfg.band_bad;
		status_word[scp_pkg::ST_RATIO_BAD]   = cfg.ratio_bad;
		status_word[scp_pkg::ST_CFG_LIVE_WR] = live_wr_reg;
		status_word[scp_pkg::ST_RSVD_WR]     = rsvd_wr_reg;
	end

	// ------------------------------------------------------------
	// register next values
	// ------------------------------------------------------------
	always_comb begin
		loop_setup_next  = loop_setup_reg;
		analog_trim_next = analog_trim_reg;
		power_ctrl_next  = power_ctrl_reg;
		live_wr_next     = live_wr_reg;
		rsvd_wr_next     = rsvd_wr_reg;
		rdata_next       = 16'h0000;

		// bits 7-6 are never written, so they stay zero
		if (wr_loop) begin
			loop_setup_next = scp_merge(loop_setup_reg, i_wdata,
				scp_pkg::LOOP_SETUP_WMASK);
		end
		if (wr_trim) begin
			analog_trim_next = i_wdata;
		end
		if (wr_power) begin
			power_ctrl_next = scp_merge(power_ctrl_reg, i_wdata,
				scp_pkg::POWER_CTRL_WMASK);
		end

		// sticky flags: write 1 clears, a new event wins
		if (wr_status && i_wdata[scp_pkg::ST_CFG_LIVE_WR]) begin
			live_wr_next = 1'b0;
		end
		if (wr_status && i_wdata[scp_pkg::ST_RSVD_WR]) begin
			rsvd_wr_next = 1'b0;
		end
		// writes are still accepted; the loop may glitch, so flag it
		if ((wr_loop || wr_trim) &&
			power_ctrl_reg[scp_pkg::POWER_ON_BIT]) begin
			live_wr_next = 1'b1;
		end
		if (wr_rsvd) begin
			rsvd_wr_next = 1'b1;
		end

		// read data valid in the following cycle only
		if (i_rd) begin
			unique case (i_addr)
				scp_pkg::OFF_PLL_LOOP_SETUP:    rdata_next = loop_setup_reg;
				scp_pkg::OFF_PLL_ANALOG_TRIM:   rdata_next = analog_trim_reg;
				scp_pkg::OFF_PLL_POWER_CONTROL: rdata_next = power_ctrl_reg;
				scp_pkg::OFF_SYNTH_STATUS:      rdata_next = status_word;
				default:                        rdata_next = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// every register clears, so the loop starts powered down
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			loop_setup_reg  <= scp_pkg::RST_PLL_LOOP_SETUP;
			analog_trim_reg <= scp_pkg::RST_PLL_ANALOG_TRIM;
			power_ctrl_reg  <= scp_pkg::RST_PLL_POWER_CONTROL;
			live_wr_reg     <= 1'b0;
			rsvd_wr_reg     <= 1'b0;
			rdata_reg       <= scp_pkg::RST_RDATA;
		end else begin
			loop_setup_reg  <= loop_setup_next;
			analog_trim_reg <= analog_trim_next;
			power_ctrl_reg  <= power_ctrl_next;
			live_wr_reg     <= live_wr_next;
			rsvd_wr_reg     <= rsvd_wr_next;
			rdata_reg       <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_rdata                  = rdata_reg;
	assign o_filter_resistance_code = cfg.filter_resistance_code;
	assign o_vco_band_code          = cfg.vco_band_code;
	assign o_vco_ratio_factor       = cfg.vco_ratio_factor;
	assign o_feedback_factor        = cfg.feedback_factor;
	assign o_analog_trim            = analog_trim_reg;
	// 0 holds the loop in power down
	assign o_synth_power_on =
		power_ctrl_reg[scp_pkg::POWER_ON_BIT];
	assign o_vco_ratio_value        = cfg.ratio_value;
	assign o_feedback_multiplier    = cfg.fb_multiplier;
	// flagged only: software still owns the choice of code
	assign o_cfg_reserved_code =
		cfg.flt_bad || cfg.band_bad || cfg.ratio_bad;

endmodule : scp_pll_regs

`default_nettype wire

//--- dv/scp_pll_regs_sva.sv
// assertions and covers for the synthesiser register bank
`timescale 1ns/100ps
`default_nettype none

module scp_pll_regs_sva (
	input wire logic        i_sys_clk,
	input wire logic        i_reset,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic [3:0]  o_filter_resistance_code,
	input wire logic [3:0]  o_vco_band_code,
	input wire logic [1:0]  o_vco_ratio_factor,
	input wire logic [3:0]  o_feedback_factor,
	input wire logic [15:0] o_analog_trim,
	input wire logic        o_synth_power_on,
	input wire logic [3:0]  o_vco_ratio_value,
	input wire logic [4:0]  o_feedback_multiplier,
	input wire logic        o_cfg_reserved_code
);
	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);
	logic       wl;
	logic       wt;
	logic       wp;
	logic       rl;
	logic       rp;
	logic [3:0] f;
	assign wl = i_wr && i_addr == scp_pkg::OFF_PLL_LOOP_SETUP;
	assign wt = i_wr && i_addr == scp_pkg::OFF_PLL_ANALOG_TRIM;
	assign wp = i_wr && i_addr == scp_pkg::OFF_PLL_POWER_CONTROL;
	assign rl = i_rd && i_addr == scp_pkg::OFF_PLL_LOOP_SETUP;
	assign rp = i_rd && i_addr == scp_pkg::OFF_PLL_POWER_CONTROL;
	assign f = o_filter_resistance_code;

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_wr_loop;
		wl |=> {f, o_vco_band_code, o_vco_ratio_factor, o_feedback_factor}
			== {$past(i_wdata[15:8]), $past(i_wdata[5:0])};
	endproperty
	a_wr_loop: assert property (p_wr_loop) else $error("loop write lost");
	property p_rd_loop;
		rl |=> o_rdata == {f, o_vco_band_code, 2'h0, o_vco_ratio_factor,
			o_feedback_factor};
	endproperty
	a_rd_loop: assert property (p_rd_loop) else $error("loop read bad");
	property p_wr_trim;
		wt |=> o_analog_trim == $past(i_wdata);
	endproperty
	a_wr_trim: assert property (p_wr_trim) else $error("trim write lost");
	property p_hold_trim;
		!wt |=> $stable(o_analog_trim);
	endproperty
	a_hold_trim: assert property (p_hold_trim) else $error("trim moved");
	property p_wr_pwr;
		wp |=> o_synth_power_on == $past(i_wdata[0]);
	endproperty
	a_wr_pwr: assert property (p_wr_pwr) else $error("power write lost");
	property p_rd_pwr;
		rp |=> o_rdata == {15'h0000, o_synth_power_on};
	endproperty
	a_rd_pwr: assert property (p_rd_pwr) else $error("power read bad");
	property p_idle;
		!i_rd |=> o_rdata == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("read data stayed");
	property p_ratio;
		o_vco_ratio_value == ((o_vco_ratio_factor == 2'h0) ? 4'h0
			: 4'h1 << o_vco_ratio_factor);
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio decode bad");
	property p_fb;
		o_feedback_multiplier == {1'h0, o_feedback_factor} + 5'h01;
	endproperty
	a_fb: assert property (p_fb) else $error("multiplier bad");
	property p_rsvd;
		o_cfg_reserved_code == (!(f == 4'h8 || f == 4'hA)
			|| o_vco_band_code == 4'h0 || o_vco_band_code > 4'h8
			|| o_vco_ratio_factor == 2'h0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved flag bad");
	c_power: cover property (wp && i_wdata[0]);
	c_read: cover property (rl);
	c_x8: cover property (o_vco_ratio_factor == 2'h3);
endmodule : scp_pll_regs_sva

bind scp_pll_regs scp_pll_regs_sva u_scp_pll_regs_sva (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_filter_resistance_code(o_filter_resistance_code),
	.o_vco_band_code(o_vco_band_code),
	.o_vco_ratio_factor(o_vco_ratio_factor),
	.o_feedback_factor(o_feedback_factor), .o_analog_trim(o_analog_trim),
	.o_synth_power_on(o_synth_power_on),
	.o_vco_ratio_value(o_vco_ratio_value),
	.o_feedback_multiplier(o_feedback_multiplier),
	.o_cfg_reserved_code(o_cfg_reserved_code)
);

`default_nettype wire

//--- dv/scp_pll_regs_tb_top.sv
// self-checking bench for the synthesiser register bank
`timescale 1ns/100ps
`default_nettype none

module scp_pll_regs_tb_top;
	logic        i_sys_clk = 1'h0;
	logic        i_reset   = 1'h1;
	logic [15:0] i_addr    = 16'h0000;
	logic [15:0] i_wdata   = 16'h0000;
	logic        i_wr      = 1'h0;
	logic        i_rd      = 1'h0;
	logic [15:0] o_rdata;
	logic [3:0]  flt;
	logic [3:0]  band;
	logic [1:0]  ratio;
	logic [3:0]  fb;
	logic [15:0] trim;
	logic        pwr;
	logic [3:0]  rval;
	logic [4:0]  mult;
	logic        rsvd;
	logic [15:0] a;
	logic [15:0] d;
	logic [15:0] e;
	int          bad_count   = 0;
	int          comparisons = 0;
	int          cycles      = 0;
	// address, write data, expected readback
	logic [47:0] rows [10] = '{
		{16'h0414, 16'hFFFF, 16'hFF3F}, {16'h0414, 16'h8820, 16'h8820},
		{16'h0414, 16'h8111, 16'h8111}, {16'h0416, 16'hFFFF, 16'hFFFF},
		{16'h0416, 16'h0040, 16'h0040}, {16'h0418, 16'hFFFF, 16'h0001},
		{16'h0418, 16'h0000, 16'h0000}, {16'h0412, 16'hFFFF, 16'h0000},
		{16'h04A0, 16'hFFFF, 16'h0000}, {16'h0414, 16'hA333, 16'hA333}};

	always #5 i_sys_clk = ~i_sys_clk;

	scp_pll_regs u_scp_pll_regs (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_filter_resistance_code(flt), .o_vco_band_code(band),
		.o_vco_ratio_factor(ratio), .o_feedback_factor(fb),
		.o_analog_trim(trim), .o_synth_power_on(pwr),
		.o_vco_ratio_value(rval), .o_feedback_multiplier(mult),
		.o_cfg_reserved_code(rsvd)
	);

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] s, input logic [15:0] x,
		input string n);
		comparisons++;
		if (s !== x) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	// called at a rising edge; returns at the edge that samples it
	task automatic op(input logic w, input logic r, input logic [15:0] ad,
		input logic [15:0] wd);
		i_wr <= w;
		i_rd <= r;
		i_addr <= ad;
		i_wdata <= wd;
		@(posedge i_sys_clk);
	endtask : op

	task automatic rd(input logic [15:0] ad, input logic [15:0] x);
		op(1'h0, 1'h1, ad, 16'h0000);
		i_rd <= 1'h0;
		@(negedge i_sys_clk);
		chk(o_rdata, x, "rdata");
		@(posedge i_sys_clk);
	endtask : rd

	// hang guard, well above the expected run of some 80 cycles
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_reset <= 1'h0;
		@(negedge i_sys_clk);
		chk({11'h000, mult}, 16'h0001, "mult");
		chk({15'h0000, rsvd}, 16'h0001, "reserved");
		@(posedge i_sys_clk);
		rd(16'h0414, 16'h0000);
		rd(16'h0416, 16'h0000);
		rd(16'h0418, 16'h0000);
		foreach (rows[k]) begin
			{a, d, e} = rows[k];
			op(1'h1, 1'h0, a, d);
			rd(a, e);
		end
		chk({12'h000, rval}, 16'h0008, "ratio");
		chk({11'h000, mult}, 16'h0004, "mult");
		// enable, then change configuration while live; reads back to back
		op(1'h1, 1'h0, 16'h0418, 16'h0001);
		op(1'h1, 1'h0, 16'h0414, 16'h8111);
		op(1'h0, 1'h1, 16'h0414, 16'h0000);
		i_addr <= 16'h0418;
		@(negedge i_sys_clk);
		chk(o_rdata, 16'h8111, "rdata");
		@(posedge i_sys_clk);
		i_rd <= 1'h0;
		@(negedge i_sys_clk);
		chk(o_rdata, 16'h0001, "rdata");
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk(o_rdata, 16'h0000, "rdata");
		@(posedge i_sys_clk);
		// sticky flags: live write and reserved slot write, then clear
		rd(16'h04FE, 16'h0031);
		op(1'h1, 1'h0, 16'h04FE, 16'h0030);
		rd(16'h04FE, 16'h0001);
		// legal bring-up: disable, configure, enable
		op(1'h1, 1'h0, 16'h0418, 16'h0000);
		op(1'h1, 1'h0, 16'h0414, 16'hA333);
		op(1'h1, 1'h0, 16'h0416, 16'h0040);
		op(1'h1, 1'h0, 16'h0418, 16'h0001);
		rd(16'h04FE, 16'h0001);
		chk({15'h0000, rsvd}, 16'h0000, "reserved");
		chk({12'h000, rval}, 16'h0008, "ratio");
		chk({flt, band, 2'h0, ratio, fb}, 16'hA333, "fields");
		chk({15'h0000, pwr}, 16'h0001, "power");
		chk(trim, 16'h0040, "trim");
		// second reset in mid-run clears every register
		i_reset <= 1'h1;
		@(negedge i_sys_clk);
		chk({15'h0000, pwr}, 16'h0000, "power");
		chk(trim, 16'h0000, "trim");
		@(posedge i_sys_clk);
		i_reset <= 1'h0;
		rd(16'h0414, 16'h0000);
		end_of_test();
	end
endmodule : scp_pll_regs_tb_top

`default_nettype wire
